// *** rtl/audio_port_pkg.sv ***
// Purpose: Constants and carrier types for the serial audio port
// Assumes: AXI4-Lite register bus with 32-bit data
// Notes: Offsets are byte addresses, one aligned word per register
package audio_port_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DIV_OFS = 8'h04;
    localparam logic [7:0] REC_L_OFS = 8'h08;
    localparam logic [7:0] REC_R_OFS = 8'h0c;
    localparam logic [7:0] PLAY_L_OFS = 8'h10;
    localparam logic [7:0] PLAY_R_OFS = 8'h14;
    localparam logic [7:0] STAT_OFS = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int F_FMT = 0;
    localparam int F_WL = 2;
    localparam int F_POL = 4;
    localparam int F_BINV = 7;
    localparam int F_TRIS = 8;
    localparam int F_RSLOT = 10;
    localparam int F_RTDM = 11;
    localparam int F_PSLOT = 12;
    localparam int F_PTDM = 13;
    localparam int F_BOE = 16;
    localparam int F_FOE = 17;
    localparam int F_BDIV = 0;
    localparam int F_FRATE = 8;
    localparam int F_PLAY_NEW = 0;
    // ----------------------------------------
    // Codes and reset values
    // ----------------------------------------
    localparam logic [1:0] FMT_RJ = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_20 = 2'h1;
    localparam logic [1:0] WL_24 = 2'h2;
    localparam logic [1:0] WL_32 = 2'h3;
    localparam logic [5:0] SAMPLE_W = 6'h18;
    localparam logic [1:0] FMT_RST = FMT_I2S;
    localparam logic [1:0] WL_RST = WL_24;
    localparam logic [7:0] BCLK_DIV_RST = 8'h04;
    localparam logic [9:0] FRAME_RATE_RST = 10'h040;
    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;
    typedef struct packed {
        logic frame_oe;
        logic bclk_oe;
        logic play_tdm;
        logic play_slot;
        logic rec_tdm;
        logic rec_slot;
        logic tris;
        logic bclk_inv;
        logic pol;
        logic [1:0] wl;
        logic [1:0] fmt;
    } ctrl_s;
    typedef struct packed {
        logic hit;
        logic right;
        logic [5:0] idx;
    } slot_s;
    typedef struct packed {
        ctrl_s ctrl;
        logic [7:0] bdiv;
        logic [9:0] frate;
        logic [23:0] rec_l;
        logic [23:0] rec_r;
        logic [23:0] play_l;
        logic [23:0] play_r;
        logic play_new;
        logic aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        axi_rsp_s rsp;
        logic [7:0] divcnt;
        logic mbclk;
        logic e_q;
        logic f_q;
        logic [9:0] pos;
        logic [9:0] len;
        logic [9:0] fcnt;
        logic fout;
        logic [23:0] rx_sr;
        logic dout;
        logic doe;
        logic bclk_oe_o;
        logic frame_oe_o;
        logic [5:0] tx_idx;
        logic tx_right;
        logic tx_hit;
    } state_s;
endpackage

// *** rtl/audio_serial_port.sv ***
// Purpose: Serial audio port with record output, playback input, bit and frame clocks
// Assumes: Pin inputs synchronous to CLOCK_I; bit clock well below CLOCK_I/2
// Notes: Registers over AXI4-Lite; bit clock edges are detected, not used as a clock
`timescale 1ns/1ns
module audio_serial_port
    import audio_port_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    // Register bus
    input wire axi_req_s AXI_REQ_I,
    output axi_rsp_s AXI_RSP_O,
    // Bit clock pin
    input wire logic BCLK_I,
    output logic BCLK_O,
    output logic BCLK_OE_O,
    // Frame clock pin
    input wire logic FRAME_I,
    output logic FRAME_O,
    output logic FRAME_OE_O,
    // Data pins
    input wire logic PLAYBACK_DATA_I,
    output logic RECORD_DATA_O,
    output logic RECORD_DATA_OE_O
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [5:0] wl_bits(input logic [1:0] wl);
        logic [5:0] w;
        case (wl)
            WL_16: w = 6'h10;
            WL_20: w = 6'h14;
            WL_24: w = 6'h18;
            default: w = 6'h20;
        endcase
        return w;
    endfunction

    function automatic logic [9:0] word_start(input ctrl_s c, input logic tdm, input logic slot,
                                              input logic [9:0] len);
        logic [9:0] b;
        logic two;
        logic [9:0] ws;
        b = {4'h0, wl_bits(c.wl)};
        two = tdm && slot;
        case (c.fmt)
            FMT_RJ: ws = len - ((tdm && !slot) ? (b << 1) : b);
            FMT_LJ: ws = two ? b : 10'h000;
            FMT_I2S: ws = 10'h001 + (two ? b : 10'h000);
            default: ws = (c.pol ? 10'h000 : 10'h001) + (two ? (b << 1) : 10'h000);
        endcase
        return ws;
    endfunction

    function automatic slot_s decode(input logic [9:0] pos, input logic [9:0] start,
                                     input logic [5:0] w, input logic dsp);
        slot_s r;
        logic [9:0] k;
        logic [9:0] span;
        k = pos - start;
        span = dsp ? {3'h0, w, 1'b0} : {4'h0, w};
        r.hit = (pos >= start) && (k < span);
        r.right = dsp && (k >= {4'h0, w});
        r.idx = r.right ? 6'(k - {4'h0, w}) : k[5:0];
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    state_s s;
    state_s n;
    axi_req_s q;
    assign q = AXI_REQ_I;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] cr;
        logic [31:0] dr;
        logic [31:0] rd;
        logic [31:0] wv;
        logic err;
        logic [5:0] w;
        logic dsp;
        logic bsrc;
        logic e;
        logic rise;
        logic fall;
        logic fsrc;
        logic trans;
        logic left;
        logic lv;
        logic [7:0] bd;
        logic [9:0] tp;
        slot_s rx;
        slot_s tx;
        logic [23:0] word;
        logic [23:0] src;
        cr = '0;
        dr = '0;
        rd = '0;
        wv = '0;
        err = 1'b0;
        w = '0;
        dsp = 1'b0;
        bsrc = 1'b0;
        e = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        fsrc = 1'b0;
        trans = 1'b0;
        left = 1'b0;
        lv = 1'b0;
        bd = '0;
        tp = '0;
        rx = '0;
        tx = '0;
        word = '0;
        src = '0;
        n = s;
        cr[F_FMT +: 2] = s.ctrl.fmt;
        cr[F_WL +: 2] = s.ctrl.wl;
        cr[F_POL] = s.ctrl.pol;
        cr[F_BINV] = s.ctrl.bclk_inv;
        cr[F_TRIS] = s.ctrl.tris;
        cr[F_RSLOT] = s.ctrl.rec_slot;
        cr[F_RTDM] = s.ctrl.rec_tdm;
        cr[F_PSLOT] = s.ctrl.play_slot;
        cr[F_PTDM] = s.ctrl.play_tdm;
        cr[F_BOE] = s.ctrl.bclk_oe;
        cr[F_FOE] = s.ctrl.frame_oe;
        dr[F_BDIV +: 8] = s.bdiv;
        dr[F_FRATE +: 10] = s.frate;

        // ----------------------------------------
        // Write channel
        // ----------------------------------------
        if (s.rsp.bvalid && q.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        if (s.rsp.awready && q.awvalid) begin
            n.aw_have = 1'b1;
            n.awaddr = q.awaddr;
        end
        if (s.rsp.wready && q.wvalid) begin
            n.w_have = 1'b1;
            n.wdata = q.wdata;
            n.wstrb = q.wstrb;
        end
        if (n.aw_have && n.w_have && !n.rsp.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp = RESP_OKAY;
            if (n.awaddr == CTRL_OFS) begin
                wv = merge(cr, n.wdata, n.wstrb);
                n.ctrl.fmt = wv[F_FMT +: 2];
                n.ctrl.wl = wv[F_WL +: 2];
                n.ctrl.pol = wv[F_POL];
                n.ctrl.bclk_inv = wv[F_BINV];
                n.ctrl.tris = wv[F_TRIS];
                n.ctrl.rec_slot = wv[F_RSLOT];
                n.ctrl.rec_tdm = wv[F_RTDM];
                n.ctrl.play_slot = wv[F_PSLOT];
                n.ctrl.play_tdm = wv[F_PTDM];
                n.ctrl.bclk_oe = wv[F_BOE];
                n.ctrl.frame_oe = wv[F_FOE];
            end else if (n.awaddr == DIV_OFS) begin
                wv = merge(dr, n.wdata, n.wstrb);
                n.bdiv = wv[F_BDIV +: 8];
                n.frate = wv[F_FRATE +: 10];
            end else if (n.awaddr == REC_L_OFS) begin
                wv = merge({8'h00, s.rec_l}, n.wdata, n.wstrb);
                n.rec_l = wv[23:0];
            end else if (n.awaddr == REC_R_OFS) begin
                wv = merge({8'h00, s.rec_r}, n.wdata, n.wstrb);
                n.rec_r = wv[23:0];
            end else if (n.awaddr == STAT_OFS) begin
                if (n.wstrb[0] && n.wdata[F_PLAY_NEW]) begin
                    n.play_new = 1'b0;
                end
            end else if (n.awaddr != PLAY_L_OFS && n.awaddr != PLAY_R_OFS) begin
                n.rsp.bresp = RESP_SLVERR;
            end
        end
        n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
        n.rsp.wready = !n.w_have && !n.rsp.bvalid;

        // ----------------------------------------
        // Read channel
        // ----------------------------------------
        if (s.rsp.rvalid && q.rready) begin
            n.rsp.rvalid = 1'b0;
        end
        if (q.araddr == CTRL_OFS) begin
            rd = cr;
        end else if (q.araddr == DIV_OFS) begin
            rd = dr;
        end else if (q.araddr == REC_L_OFS) begin
            rd = {8'h00, s.rec_l};
        end else if (q.araddr == REC_R_OFS) begin
            rd = {8'h00, s.rec_r};
        end else if (q.araddr == PLAY_L_OFS) begin
            rd = {8'h00, s.play_l};
        end else if (q.araddr == PLAY_R_OFS) begin
            rd = {8'h00, s.play_r};
        end else if (q.araddr == STAT_OFS) begin
            rd[F_PLAY_NEW] = s.play_new;
        end else begin
            err = 1'b1;
        end
        if (s.rsp.arready && q.arvalid) begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rdata = rd;
            n.rsp.rresp = err ? RESP_SLVERR : RESP_OKAY;
        end
        n.rsp.arready = !n.rsp.rvalid;

        // ----------------------------------------
        // Clock generation and edge detection
        // ----------------------------------------
        w = wl_bits(s.ctrl.wl);
        dsp = s.ctrl.fmt == FMT_DSP;
        bd = (s.bdiv == 8'h00) ? 8'h01 : s.bdiv;
        if (8'(s.divcnt + 8'h01) >= bd) begin
            n.divcnt = 8'h00;
            n.mbclk = !s.mbclk;
        end else begin
            n.divcnt = 8'(s.divcnt + 8'h01);
        end
        // Mixed clocking: frame divider follows whichever bit clock is live
        bsrc = s.ctrl.bclk_oe ? s.mbclk : BCLK_I;
        e = bsrc ^ s.ctrl.bclk_inv;
        n.e_q = e;
        rise = e && !s.e_q;
        fall = !e && s.e_q;
        lv = (s.ctrl.fmt != FMT_I2S) ^ s.ctrl.pol;
        if (fall) begin
            n.fcnt = (10'(s.fcnt + 10'h001) >= s.frate) ? 10'h000 : 10'(s.fcnt + 10'h001);
            if (dsp) begin
                n.fout = n.fcnt == 10'h000;
            end else begin
                n.fout = (n.fcnt < (s.frate >> 1)) ? lv : !lv;
            end
        end
        fsrc = s.ctrl.frame_oe ? n.fout : FRAME_I;
        trans = dsp ? (fsrc && !s.f_q) : (fsrc != s.f_q);
        left = ((s.ctrl.fmt == FMT_I2S) ? !fsrc : fsrc) ^ s.ctrl.pol;

        // ----------------------------------------
        // Receive on rising edge
        // ----------------------------------------
        if (rise) begin
            n.f_q = fsrc;
            n.pos = trans ? 10'h000 : 10'(s.pos + 10'h001);
            if (trans) begin
                n.len = 10'(s.pos + 10'h001);
            end
            rx = decode(n.pos, word_start(s.ctrl, s.ctrl.play_tdm, s.ctrl.play_slot, n.len), w, dsp);
            if (rx.hit) begin
                if (rx.idx < SAMPLE_W) begin
                    n.rx_sr = {s.rx_sr[22:0], PLAYBACK_DATA_I};
                end
                if (rx.idx == 6'(w - 6'h01)) begin
                    word = (w >= SAMPLE_W) ? n.rx_sr : 24'(n.rx_sr << (SAMPLE_W - w));
                    if (dsp ? rx.right : !left) begin
                        n.play_r = word;
                    end else begin
                        n.play_l = word;
                    end
                    // Set wins over a clear in the same cycle
                    n.play_new = 1'b1;
                end
            end
        end

        // ----------------------------------------
        // Transmit on falling edge
        // ----------------------------------------
        if (fall) begin
            tp = (fsrc != s.f_q && (!dsp || fsrc)) ? 10'h000 : 10'(s.pos + 10'h001);
            tx = decode(tp, word_start(s.ctrl, s.ctrl.rec_tdm, s.ctrl.rec_slot, s.len), w, dsp);
            src = (dsp ? tx.right : !left) ? s.rec_r : s.rec_l;
            n.tx_idx = tx.idx;
            n.tx_right = dsp ? tx.right : !left;
            n.tx_hit = tx.hit;
            if (tx.hit && tx.idx < SAMPLE_W) begin
                n.dout = src[5'(6'h17 - tx.idx)];
                n.doe = 1'b1;
            end else begin
                n.dout = 1'b0;
                n.doe = tx.hit ? 1'b0 : !s.ctrl.rec_tdm;
            end
        end
        if (s.ctrl.tris || (s.ctrl.rec_tdm && !n.tx_hit)) begin
            n.doe = 1'b0;
        end
        n.bclk_oe_o = s.ctrl.bclk_oe && !s.ctrl.tris;
        n.frame_oe_o = s.ctrl.frame_oe && !s.ctrl.tris;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s <= '0;
            s.ctrl.fmt <= FMT_RST;
            s.ctrl.wl <= WL_RST;
            s.bdiv <= BCLK_DIV_RST;
            s.frate <= FRAME_RATE_RST;
        end else begin
            s <= n;
        end
    end

    assign AXI_RSP_O = s.rsp;
    assign BCLK_O = s.mbclk;
    assign BCLK_OE_O = s.bclk_oe_o;
    assign FRAME_O = s.fout;
    assign FRAME_OE_O = s.frame_oe_o;
    assign RECORD_DATA_O = s.dout;
    assign RECORD_DATA_OE_O = s.doe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_B_I);

    frame_pulse_a: assert property (s.ctrl.fmt == FMT_DSP && $stable(s.ctrl.fmt) && $changed(s.fcnt)
                                    && s.fout |-> s.fcnt == 10'h000)
        else $error("frame pulse outside frame start");
    slot_release_a: assert property ($past(s.ctrl.rec_tdm) && RECORD_DATA_OE_O |-> s.tx_hit)
        else $error("record line driven outside own slot");
    gap_bits_a: assert property (RECORD_DATA_OE_O && s.tx_hit |-> s.tx_idx < SAMPLE_W)
        else $error("record line driven past 24th bit");
    tris_all_a: assert property (s.ctrl.tris |=> !RECORD_DATA_OE_O && !BCLK_OE_O && !FRAME_OE_O)
        else $error("pins driven while tristated");
    bclk_div_a: assert property ($changed(s.mbclk) && s.bdiv == 8'h04 && $stable(s.bdiv)
                                 |=> !$changed(s.mbclk) [*3] ##1 $changed(s.mbclk))
        else $error("bit clock half period wrong");
    msb_first_a: assert property (RECORD_DATA_OE_O && s.tx_hit && s.tx_idx == 6'h00 && !s.tx_right
                                  && $stable(s.rec_l) |-> RECORD_DATA_O == s.rec_l[23])
        else $error("first bit is not the msb");
    oe_mixed_a: assert property ($rose(s.ctrl.bclk_oe) && !s.ctrl.tris |=> BCLK_OE_O)
        else $error("bit clock driver not enabled");
    bresp_hold_a: assert property (s.rsp.bvalid && !q.bready |=> s.rsp.bvalid && $stable(s.rsp.bresp))
        else $error("write response dropped");
    rvalid_hold_a: assert property (s.rsp.rvalid && !q.rready |=> s.rsp.rvalid && $stable(s.rsp.rdata))
        else $error("read data dropped");
endmodule

// *** tb/audio_host_model.sv ***
// Purpose: Host-side partner that plays words in and records words out
// Assumes: Device masters both clocks; half frame holds the chosen slot
// Notes: Idle data line toggles on every bit clock fall, no pull
`timescale 1ns/1ns
module audio_host_model (
    // Link
    input wire logic bclk_i,
    input wire logic frame_i,
    input wire logic rec_i,
    output logic play_o,
    // Format
    input wire logic [5:0] off_i,
    input wire logic dsp_i,
    input wire logic left_lvl_i,
    // Words
    input wire logic [23:0] tx_l_i,
    input wire logic [23:0] tx_r_i,
    output logic [23:0] cap_l_o,
    output logic [23:0] cap_r_o
);
    int pos = 0;
    logic last_f = 1'b0;
    initial play_o = 1'b0;
    // Frame start: DSP counts from a rise, others from any change
    function automatic logic fresh(input logic f);
        return dsp_i ? (f & !last_f) : (f !== last_f);
    endfunction
    // Capture on rises, MSB first; we never drive the clocks
    always @(posedge bclk_i) begin
        int i;
        pos = fresh(frame_i) ? 0 : pos + 1;
        last_f = frame_i;
        i = pos - int'(off_i);
        if (dsp_i && i >= 0 && i < 48) begin
            if (i < 24) cap_l_o[23-i] = rec_i;
            else cap_r_o[47-i] = rec_i;
        end else if (!dsp_i && i >= 0 && i < 24) begin
            if (frame_i == left_lvl_i) cap_l_o[23-i] = rec_i;
            else cap_r_o[23-i] = rec_i;
        end
    end
    // Drive after the fall, once the frame clock has settled
    always @(negedge bclk_i) begin
        int i;
        logic lft;
        #80;
        i = (fresh(frame_i) ? 0 : pos + 1) - int'(off_i);
        lft = dsp_i ? (i < 24) : (frame_i == left_lvl_i);
        if (dsp_i && i >= 24) i = i - 24;
        if (i >= 0 && i < 24) play_o <= lft ? tx_l_i[23-i] : tx_r_i[23-i];
        else play_o <= ~play_o;
    end
endmodule

// *** tb/codec_serial_audio_port_tdm_bench.sv ***
// Purpose: Self-checking bench for the serial audio port
// Assumes: Device as clock master; bit clock divider at reset value
// Notes: Register rows first, then one pass per data format, two for DSP
`timescale 1ns/1ns
module codec_serial_audio_port_tdm_bench
    import audio_port_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] rsp;} row_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    axi_req_s req = '0;
    axi_rsp_s rsp;
    logic bclk_o, bclk_oe, frame_o, frame_oe, play, rec, rec_oe;
    logic [5:0] off = 6'h00;
    logic dsp = 1'b0;
    logic lvl = 1'b1;
    logic [23:0] tx_l = 24'h000000;
    logic [23:0] tx_r = 24'h000000;
    logic [23:0] cap_l, cap_r;
    wire bline = bclk_oe ? bclk_o : 1'b0;
    wire fline = frame_oe ? frame_o : 1'b0;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [1:0] resp;
    row_s rows[9] = '{'{1'b0, CTRL_OFS, 32'h0000000a, RESP_OKAY}, '{1'b0, DIV_OFS, 32'h00004004, RESP_OKAY},
        '{1'b0, STAT_OFS, 32'h0, RESP_OKAY}, '{1'b0, 8'h1c, 32'h0, RESP_SLVERR}, '{1'b1, 8'h1c, 32'h0, RESP_SLVERR},
        '{1'b1, PLAY_L_OFS, 32'hffffff, RESP_OKAY}, '{1'b0, PLAY_L_OFS, 32'h0, RESP_OKAY},
        '{1'b1, REC_L_OFS, 32'habcdef, RESP_OKAY}, '{1'b0, REC_L_OFS, 32'habcdef, RESP_OKAY}};
    logic [1:0] fmts[5] = '{FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP, FMT_DSP};
    logic [5:0] offs[5] = '{6'h08, 6'h00, 6'h01, 6'h00, 6'h01};
    logic lvls[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    always #20 clk = ~clk;
    audio_serial_port audio_serial_port_inst (.CLOCK_I(clk), .RST_B_I(rst_b), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
        .BCLK_I(bline), .BCLK_O(bclk_o), .BCLK_OE_O(bclk_oe), .FRAME_I(fline), .FRAME_O(frame_o),
        .FRAME_OE_O(frame_oe), .PLAYBACK_DATA_I(play), .RECORD_DATA_O(rec), .RECORD_DATA_OE_O(rec_oe));
    audio_host_model audio_host_model_inst (.bclk_i(bline), .frame_i(fline), .rec_i(rec_oe ? rec : 1'bz),
        .play_o(play), .off_i(off), .dsp_i(dsp), .left_lvl_i(lvl), .tx_l_i(tx_l), .tx_r_i(tx_r),
        .cap_l_o(cap_l), .cap_r_o(cap_r));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Each channel moves at the rising edge where valid and ready are both high
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d, wstrb:4'hf, bready:1'b1, default:'0};
        for (int n = 0; n < 50 && !b; n++) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                b = 1'b1;
                resp = rsp.bresp;
                req.bready <= 1'b0;
            end
        end
        if (!b) begin
            fail_count++;
            finish_test();
        end
        @(posedge clk);
    endtask
    task automatic bus_read(input logic [7:0] a);
        logic r;
        r = 1'b0;
        req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
        for (int n = 0; n < 50 && !r; n++) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                r = 1'b1;
                rd = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
            end
        end
        if (!r) begin
            fail_count++;
            finish_test();
        end
        @(posedge clk);
    endtask
    // High time and rise-to-rise period in system clocks
    task automatic measure(input logic sel, output int hi, output int per);
        int t0;
        logic v, pv;
        t0 = -1;
        hi = 0;
        per = 0;
        pv = 1'b1;
        for (int k = 0; k < 1500 && per == 0; k++) begin
            @(posedge clk);
            v = sel ? frame_o : bclk_o;
            if (v && !pv && t0 >= 0) per = k - t0;
            if (v && !pv && t0 < 0) t0 = k;
            if (v && t0 >= 0 && per == 0) hi++;
            pv = v;
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        int h, p;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) bus_write(rows[i].a, rows[i].d);
            else bus_read(rows[i].a);
            if (!rows[i].wr) check("rdata", rd, rows[i].d);
            check("resp", {30'h0, resp}, {30'h0, rows[i].rsp});
        end
        // Every format code, master clocks; DSP mode B then mode A
        foreach (fmts[f]) begin
            off <= offs[f];
            dsp <= (f >= 3);
            lvl <= lvls[f];
            tx_l <= 24'hc3a501 + 24'(f);
            tx_r <= 24'h5e0f7b + 24'(f);
            bus_write(REC_L_OFS, 32'h9a5c30 + 32'(f));
            bus_write(REC_R_OFS, 32'h3c5a91 ^ 32'(f));
            bus_write(CTRL_OFS, 32'h30000 | (32'(f == 3) << F_POL) | (32'(WL_24) << F_WL) | 32'(fmts[f]));
            repeat (1600) @(posedge clk);
            check("clock drivers", {30'h0, bclk_oe, frame_oe}, 32'h3);
            check("record left", cap_l, 32'h9a5c30 + 32'(f));
            check("record right", cap_r, 32'h3c5a91 ^ 32'(f));
            bus_read(PLAY_L_OFS);
            check("playback left", rd, 32'hc3a501 + 32'(f));
            bus_read(PLAY_R_OFS);
            check("playback right", rd, 32'h5e0f7b + 32'(f));
            bus_read(STAT_OFS);
            check("word flag", rd & 32'h1, 32'h1);
        end
        measure(1'b0, h, p);
        check("bit clock period", p, 32'd8);
        measure(1'b1, h, p);
        check("frame period", p, 32'd512);
        check("frame pulse", h, 32'd8);
        // Two slots, slot 1 both ways, 32-bit words, inverted frame, longer frame
        bus_write(DIV_OFS, 32'h00008004);
        bus_write(REC_L_OFS, 32'h5a0f3c);
        bus_write(REC_R_OFS, 32'h0f3ca5);
        off <= 6'h20;
        dsp <= 1'b0;
        lvl <= 1'b0;
        tx_l <= 24'h71e2d4;
        tx_r <= 24'h2d4b96;
        bus_write(CTRL_OFS, 32'h33c00 | (32'h1 << F_POL) | (32'(WL_32) << F_WL) | 32'(FMT_LJ));
        repeat (3200) @(posedge clk);
        check("slot record left", cap_l, 32'h5a0f3c);
        check("slot record right", cap_r, 32'h0f3ca5);
        bus_read(PLAY_L_OFS);
        check("slot playback left", rd, 32'h71e2d4);
        bus_read(PLAY_R_OFS);
        check("slot playback right", rd, 32'h2d4b96);
        bus_write(CTRL_OFS, 32'h30100);
        repeat (3) @(posedge clk);
        check("tristate", {29'h0, bclk_oe, frame_oe, rec_oe}, 32'h0);
        // Quiet link, then the sticky flag must clear on a write of one
        bus_write(CTRL_OFS, 32'h0);
        bus_write(STAT_OFS, 32'h1);
        bus_read(STAT_OFS);
        check("word flag clear", rd, 32'h0);
        finish_test();
    end
endmodule
